// [design/pulse_width_wiper_stepper.sv]
// pulse-width decoder and 6-bit wiper stepper with delayed store
// Functional notes
// - wiper is a 6-bit position among 64 equal taps
// - single-button needs down contact high and step input floating at power-up
// - single-button closures step in the last direction moved
// - dual-button: up contact steps up, down contact steps down
// - dual-button selected unless down contact is high and step input floating at power-up
// - step input acts like single-button but accepts short pulses
// - step input works in every mode
// - each recognised pulse moves the wiper one tap, or, for a dual-button contact pulse, none at that end or with both contacts low
// - inputs idle high; falling edge starts a pulse
// - contact pulse: low longer than 1 ms, up to 1 s
// - step pulse: low longer than 1 us, up to 1 s
// - highs shorter than 1 ms merge pulses into one
// - held past 1 s, step once every 100 ms until release
// - single/step operation reverses direction at either end
// - single/step: direction reverses after 1 s of inactivity
// - dual-button stops at an end until the opposite pulse
// - restore stored position; store a change after 2 s delay
`default_nettype none
module pulse_width_wiper_stepper #(
  parameter int HOLD_CYC = wiper_pkg::HOLD_CYC,
  parameter int REPEAT_CYC = wiper_pkg::REPEAT_CYC,
  parameter int IDLE_CYC = wiper_pkg::IDLE_CYC,
  parameter int STORE_CYC = wiper_pkg::STORE_CYC,
  parameter int CONTACT_MIN_CYC = wiper_pkg::CONTACT_MIN_CYC,
  parameter int GAP_MIN_CYC = wiper_pkg::GAP_MIN_CYC
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic up_contact_input,
  input wire logic down_contact_input,
  input wire logic step_input,
  // step input pull-up sense: high when the pin is left floating
  input wire logic step_floating,
  input wire logic [5:0] stored_position,
  output logic [5:0] wiper_position,
  output logic direction_up,
  output logic single_mode,
  output logic store_strobe,
  output logic [5:0] store_data
);

  // two-flop synchronisers for all pins
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sync1_q <= 4'hF;
      sync2_q <= 4'hF;
    end
    else
    begin
      sync1_q <= {step_floating, step_input, down_contact_input,
                  up_contact_input};
      sync2_q <= sync1_q;
    end
  end

  logic [2:0] raw_low;
  assign raw_low = ~sync2_q[2:0];

  // per-input pulse decoders: bit 0 up, 1 down, 2 step
  logic [2:0] step_pulse;
  logic [2:0] active;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_dec
      logic [31:0] low_cnt_q;
      logic [31:0] high_cnt_q;
      logic in_pulse_q;
      logic fired_q;
      int min_cyc;
      assign min_cyc = (gi == 2) ? wiper_pkg::DIGITAL_MIN_CYC
                                 : CONTACT_MIN_CYC;
      assign active[gi] = in_pulse_q;
      always_ff @(posedge clock or negedge arst_n)
      begin
        if (!arst_n)
        begin
          low_cnt_q <= 32'h0;
          high_cnt_q <= 32'h0;
          in_pulse_q <= 1'b0;
          fired_q <= 1'b0;
        end
        else if (raw_low[gi])
        begin
          // a short high gap keeps the same pulse going
          high_cnt_q <= 32'h0;
          in_pulse_q <= 1'b1;
          if (!in_pulse_q)
            low_cnt_q <= 32'h1;
          else if (low_cnt_q == 32'(HOLD_CYC + REPEAT_CYC))
            low_cnt_q <= 32'(HOLD_CYC);
          else
            low_cnt_q <= low_cnt_q + 32'h1;
        end
        else if (in_pulse_q)
        begin
          high_cnt_q <= high_cnt_q + 32'h1;
          if (high_cnt_q >= 32'(GAP_MIN_CYC - 1))
          begin
            in_pulse_q <= 1'b0;
            fired_q <= 1'b0;
            low_cnt_q <= 32'h0;
          end
          else if (!fired_q && low_cnt_q > 32'(min_cyc))
            fired_q <= 1'b1;
        end
      end
      // single step on release of a qualifying pulse, repeats while held
      assign step_pulse[gi] =
        (in_pulse_q && !raw_low[gi] && !fired_q && high_cnt_q == 32'h0
         && low_cnt_q > 32'(min_cyc) && low_cnt_q <= 32'(HOLD_CYC))
        || (raw_low[gi] && in_pulse_q
            && low_cnt_q == 32'(HOLD_CYC + REPEAT_CYC));
    end
  endgenerate

  // the second sync flop shows real pin levels only two edges after
  // release; latching earlier would read its reset value instead
  logic [1:0] settle_q;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      settle_q <= 2'h0;
    else
      settle_q <= {settle_q[0], 1'b1};
  end

  // mode latched once, after the synchronisers have settled
  wiper_pkg::mode_t mode_q;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      mode_q <= wiper_pkg::MODE_WAIT;
    else if (mode_q == wiper_pkg::MODE_WAIT && settle_q[1])
    begin
      // down high and step floating give single-button, else dual
      if (sync2_q[1] && sync2_q[3])
        mode_q <= wiper_pkg::MODE_SINGLE;
      else
        mode_q <= wiper_pkg::MODE_DUAL;
    end
  end
  assign single_mode = (mode_q == wiper_pkg::MODE_SINGLE);
  logic dual;
  assign dual = (mode_q == wiper_pkg::MODE_DUAL);

  // step decisions
  logic both_held;
  logic go_up;
  logic go_down;
  logic go_toggle;
  assign both_held = dual && active[0] && active[1];
  assign go_up = dual && step_pulse[0] && !both_held;
  assign go_down = dual && step_pulse[1] && !both_held;
  assign go_toggle = step_pulse[2] || (single_mode && step_pulse[0]);

  // inactivity timer on up contact and step input
  logic [31:0] idle_cnt_q;
  logic idle_flip;
  assign idle_flip = (idle_cnt_q == 32'(IDLE_CYC - 1));
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      idle_cnt_q <= 32'h0;
    else if (active[0] || active[2])
      idle_cnt_q <= 32'h0;
    else if (idle_cnt_q != 32'(IDLE_CYC))
      idle_cnt_q <= idle_cnt_q + 32'h1;
  end

  // wiper position and direction
  logic [5:0] pos_q;
  logic dir_q;
  logic loaded_q;
  // at_end: pointing past an end; near_end: next step lands on one
  logic at_end;
  logic near_end;
  assign at_end = dir_q ? (pos_q == wiper_pkg::POS_MAX)
                        : (pos_q == wiper_pkg::POS_MIN);
  assign near_end = dir_q ? (pos_q == wiper_pkg::POS_MAX - 6'h01)
                          : (pos_q == wiper_pkg::POS_MIN + 6'h01);
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pos_q <= 6'h00;
      dir_q <= 1'b1;
      loaded_q <= 1'b0;
    end
    else if (!loaded_q)
    begin
      pos_q <= stored_position;
      loaded_q <= 1'b1;
    end
    else if (go_up && pos_q != wiper_pkg::POS_MAX)
    begin
      pos_q <= pos_q + 6'h01;
      dir_q <= 1'b1;
    end
    else if (go_down && pos_q != wiper_pkg::POS_MIN)
    begin
      pos_q <= pos_q - 6'h01;
      dir_q <= 1'b0;
    end
    else if (go_toggle)
    begin
      // direction turns as the wiper lands on an end; an idle flip at an
      // end leaves it pointing outward, so that step bounces back
      if (at_end)
      begin
        pos_q <= dir_q ? pos_q - 6'h01 : pos_q + 6'h01;
        dir_q <= ~dir_q;
      end
      else
      begin
        pos_q <= dir_q ? pos_q + 6'h01 : pos_q - 6'h01;
        if (near_end)
          dir_q <= ~dir_q;
      end
    end
    else if (idle_flip)
      dir_q <= ~dir_q;
  end
  assign wiper_position = pos_q;
  assign direction_up = dir_q;

  // delayed store of changed position
  logic [31:0] store_cnt_q;
  logic [5:0] last_q;
  logic pend_q;
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      store_cnt_q <= 32'h0;
      last_q <= 6'h00;
      pend_q <= 1'b0;
      store_strobe <= 1'b0;
      store_data <= 6'h00;
    end
    else
    begin
      store_strobe <= 1'b0;
      // start from the restored value so the load is not a change
      last_q <= loaded_q ? pos_q : stored_position;
      if (loaded_q && last_q != pos_q)
      begin
        pend_q <= 1'b1;
        store_cnt_q <= 32'h0;
      end
      else if (pend_q && store_cnt_q == 32'(STORE_CYC - 1))
      begin
        pend_q <= 1'b0;
        store_strobe <= 1'b1;
        store_data <= pos_q;
      end
      else if (pend_q)
        store_cnt_q <= store_cnt_q + 32'h1;
    end
  end

  // checks
  one_tap_a: assert property (@(posedge clock) disable iff (!arst_n)
    loaded_q && $past(loaded_q) && pos_q != $past(pos_q) |->
      (pos_q - $past(pos_q) == 6'h01 || $past(pos_q) - pos_q == 6'h01))
    else $error("wiper moved more than one tap");
  dual_stop_a: assert property (@(posedge clock) disable iff (!arst_n)
    dual && pos_q == wiper_pkg::POS_MAX && !step_pulse[2] |=>
      pos_q == wiper_pkg::POS_MAX || pos_q == 6'h3E)
    else $error("wiper left top end wrongly");
  both_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    loaded_q && both_held && !step_pulse[2] |=> $stable(pos_q))
    else $error("wiper moved with both contacts low");
  mode_once_a: assert property (@(posedge clock) disable iff (!arst_n)
    mode_q != wiper_pkg::MODE_WAIT |=> $stable(mode_q))
    else $error("mode changed after latch");
  store_data_a: assert property (@(posedge clock) disable iff (!arst_n)
    store_strobe |-> store_data == $past(pos_q))
    else $error("stored value differs from wiper");
  dual_up_a: assert property (@(posedge clock) disable iff (!arst_n)
    go_up && !go_toggle && pos_q != wiper_pkg::POS_MAX |=> dir_q)
    else $error("up contact did not move up");
  end_rev_a: assert property (@(posedge clock) disable iff (!arst_n)
    loaded_q && go_toggle && !go_up && !go_down && dir_q
    && pos_q == 6'h3E |=> !dir_q && pos_q == wiper_pkg::POS_MAX)
    else $error("no reversal at top end");
  idle_rev_a: assert property (@(posedge clock) disable iff (!arst_n)
    loaded_q && idle_flip && !go_up && !go_down && !go_toggle
    |=> dir_q != $past(dir_q))
    else $error("no reversal after idle");
  store_c: cover property (@(posedge clock) disable iff (!arst_n)
    store_strobe);
  top_c: cover property (@(posedge clock) disable iff (!arst_n)
    pos_q == wiper_pkg::POS_MAX);
  single_c: cover property (@(posedge clock) disable iff (!arst_n)
    single_mode && step_pulse[0]);

endmodule : pulse_width_wiper_stepper
`default_nettype wire

// [design/wiper_pkg.sv]
// constants shared by the wiper stepper
`default_nettype none
package wiper_pkg;
  localparam int CLOCK_HZ = 125_000_000;
  localparam int TAP_COUNT = 64;
  localparam int POS_W = 6;
  localparam logic [5:0] POS_MAX = 6'h3F;
  localparam logic [5:0] POS_MIN = 6'h00;
  // times in their own units
  localparam int CONTACT_MIN_US = 1000;
  localparam int DIGITAL_MIN_US = 1;
  localparam int GAP_MIN_US = 1000;
  localparam int HOLD_MS = 1000;
  localparam int REPEAT_MS = 100;
  localparam int IDLE_MS = 1000;
  localparam int STORE_MS = 2000;
  // least times scale by whole cycles per microsecond
  localparam int CONTACT_MIN_CYC = (CONTACT_MIN_US * (CLOCK_HZ / 1_000_000));
  localparam int DIGITAL_MIN_CYC = (DIGITAL_MIN_US * (CLOCK_HZ / 1_000_000));
  localparam int GAP_MIN_CYC = (GAP_MIN_US * (CLOCK_HZ / 1_000_000));
  localparam int HOLD_CYC = HOLD_MS * (CLOCK_HZ / 1000);
  localparam int REPEAT_CYC = REPEAT_MS * (CLOCK_HZ / 1000);
  localparam int IDLE_CYC = IDLE_MS * (CLOCK_HZ / 1000);
  localparam int STORE_CYC = STORE_MS * (CLOCK_HZ / 1000);
  localparam int CNT_W = 32;
  typedef enum logic [1:0] {
    MODE_WAIT = 2'b00,
    MODE_SINGLE = 2'b01,
    MODE_DUAL = 2'b10
  } mode_t;
endpackage : wiper_pkg
`default_nettype wire

// [dv/button_model.sv]
// pushbutton and processor pin model driving the wiper stepper
`default_nettype none
module button_model (
  input wire logic clock,
  output var logic up_contact_input,
  output var logic down_contact_input,
  output var logic step_input,
  output var logic step_floating
);
  timeunit 1ns;
  timeprecision 1ps;
  // pins rest high through their pull-ups
  initial
  begin
    up_contact_input = 1'b1;
    down_contact_input = 1'b1;
    step_input = 1'b1;
    step_floating = 1'b0;
  end
  // strapping is set while reset is held, before the mode is latched
  task automatic strap(input logic single);
    step_floating <= single;
  endtask : strap
  // pin mask bit0 up, bit1 down, bit2 step; a gap under the merge
  // limit is only used where a scenario asks for a merged pulse
  task automatic press(input logic [2:0] pin, input int len, input int gap);
    @(posedge clock);
    up_contact_input <= ~pin[0];
    down_contact_input <= ~pin[1];
    step_input <= ~pin[2];
    repeat (len) @(posedge clock);
    up_contact_input <= 1'b1;
    down_contact_input <= 1'b1;
    step_input <= 1'b1;
    repeat (gap) @(posedge clock);
  endtask : press
endmodule : button_model
`default_nettype wire

// [dv/test_pulse_width_wiper_stepper.sv]
// self-checking bench for the pulse-width wiper stepper
`default_nettype none
module test_pulse_width_wiper_stepper;
  timeunit 1ns;
  timeprecision 1ps;
  // shortened counts keep the run brief
  localparam int HOLD = 400;
  localparam int REP = 50;
  localparam int IDLE = 600;
  localparam int STORE = 800;
  localparam int GAP = 40;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [5:0] stored_position = 6'h00;
  wire logic up_contact_input;
  wire logic down_contact_input;
  wire logic step_input;
  wire logic step_floating;
  logic [5:0] wiper_position;
  logic direction_up;
  logic single_mode;
  logic store_strobe;
  logic [5:0] store_data;
  int fail_count = 0;
  int comparisons = 0;
  always #4 clock = ~clock;
  pulse_width_wiper_stepper #(
    .HOLD_CYC(HOLD),
    .REPEAT_CYC(REP),
    .IDLE_CYC(IDLE),
    .STORE_CYC(STORE),
    .CONTACT_MIN_CYC(20),
    .GAP_MIN_CYC(10)
  ) i_pulse_width_wiper_stepper (
    .clock(clock),
    .arst_n(arst_n),
    .up_contact_input(up_contact_input),
    .down_contact_input(down_contact_input),
    .step_input(step_input),
    .step_floating(step_floating),
    .stored_position(stored_position),
    .wiper_position(wiper_position),
    .direction_up(direction_up),
    .single_mode(single_mode),
    .store_strobe(store_strobe),
    .store_data(store_data)
  );
  button_model i_button_model (
    .clock(clock),
    .up_contact_input(up_contact_input),
    .down_contact_input(down_contact_input),
    .step_input(step_input),
    .step_floating(step_floating)
  );
  task automatic chk_pos(input string name, input logic [5:0] exp,
                         input logic [5:0] got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_pos
  task automatic chk_bit(input string name, input logic exp, input logic got);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit
  // pins are strapped well before release so the latched mode is settled
  task automatic restart(input logic single, input logic [5:0] pos);
    @(posedge clock);
    arst_n <= 1'b0;
    stored_position <= pos;
    i_button_model.strap(single);
    repeat (5) @(posedge clock);
    arst_n <= 1'b1;
    repeat (4) @(posedge clock);
  endtask : restart
  task automatic hit(input logic [2:0] pin, input int len);
    i_button_model.press(pin, len, GAP);
  endtask : hit
  task automatic t_dual_steps();
    restart(1'b0, 6'h05);
    chk_pos("restored", 6'h05, wiper_position);
    chk_bit("dual mode", 1'b0, single_mode);
    hit(3'h1, 30);
    chk_pos("up step", 6'h06, wiper_position);
    hit(3'h2, 30);
    chk_pos("down step", 6'h05, wiper_position);
    hit(3'h1, 10);
    chk_pos("short pulse", 6'h05, wiper_position);
    i_button_model.press(3'h1, 15, 5);
    hit(3'h1, 15);
    chk_pos("merged pulse", 6'h06, wiper_position);
    hit(3'h3, 30);
    chk_pos("both low", 6'h06, wiper_position);
    // store lands one delay after the last change
    repeat (STORE + 20)
    begin
      @(posedge clock);
      if (store_strobe === 1'b1) break;
    end
    chk_bit("store strobe", 1'b1, store_strobe);
    chk_pos("store data", 6'h06, store_data);
    // the long store wait idles past the IDLE count, so direction is down
    hit(3'h4, 150);
    chk_pos("step in dual", 6'h05, wiper_position);
    $display("test dual steps finished");
  endtask : t_dual_steps
  task automatic t_dual_end();
    restart(1'b0, 6'h3E);
    hit(3'h1, 30);
    chk_pos("to top", 6'h3F, wiper_position);
    hit(3'h1, 30);
    chk_pos("held at top", 6'h3F, wiper_position);
    hit(3'h2, 30);
    chk_pos("leave top", 6'h3E, wiper_position);
    $display("test dual end finished");
  endtask : t_dual_end
  task automatic t_single();
    restart(1'b1, 6'h3E);
    chk_bit("single mode", 1'b1, single_mode);
    hit(3'h1, 30);
    chk_pos("single up", 6'h3F, wiper_position);
    chk_bit("end reverse", 1'b0, direction_up);
    hit(3'h1, 30);
    chk_pos("single down", 6'h3E, wiper_position);
    hit(3'h4, 150);
    chk_pos("step pulse", 6'h3D, wiper_position);
    hit(3'h4, 100);
    chk_pos("step too short", 6'h3D, wiper_position);
    repeat (IDLE) @(posedge clock);
    chk_bit("idle reverse", 1'b1, direction_up);
    // three repeats climb to the top, turn there and come back one tap
    hit(3'h1, HOLD + 3 * REP + 10);
    chk_pos("held repeat", 6'h3E, wiper_position);
    chk_bit("held reverse", 1'b0, direction_up);
    $display("test single finished");
  endtask : t_single
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_sim
  // the tests need a few thousand cycles; this limit only catches a hang
  initial
  begin
    repeat (30000) @(posedge clock);
    fail_count++;
    $display("BAD watchdog expired");
    end_sim();
  end
  initial
  begin
    t_dual_steps();
    t_dual_end();
    t_single();
    end_sim();
  end
endmodule : test_pulse_width_wiper_stepper
`default_nettype wire
